// >>> hw/phz_pulse.sv
/*
 phz_pulse: registered strobe following a detect level one cycle later.
 assumes synchronous active-low reset on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module phz_pulse (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// detect in, strobe out
	input wire logic detect,
	output logic strobe
);
	logic state;
	logic next_state;

	always_comb
	begin
		next_state = detect;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			state <= 1'b0;
		else
			state <= next_state;
	end

	assign strobe = state;
endmodule
`default_nettype wire

// >>> hw/phz_seq.sv
/*
 phz_seq: pc/sp sequencing anomalies of the core, applied to the stream
 of executed instructions. assumes in-order instructions with context
 from the core, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module phz_seq (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// executed instruction and core context
	input wire phz_pkg::phz_instr_t instr,
	input wire phz_pkg::phz_ctx_t ctx,
	// anomalous results
	output phz_pkg::phz_fix_t fix,
	// per-case status strobes
	output logic [6:0] hazard
);
	phz_pkg::phz_state_t st;
	phz_pkg::phz_state_t next_st;
	logic [6:0] det;

	always_comb
	begin
		next_st = st;
		next_st.fix = '0;
		det = '0;
		// a nested irq consumes the lpm/return window only when it hits
		if (ctx.irq_taken && st.lpm_after_interrupt_return_instr)
		begin
			next_st.fix.save_valid = 1'b1;
			next_st.fix.save_pc = ctx.pc + phz_pkg::PHZ_WORD_STEP;
			det[phz_pkg::PHZ_H_NEST_LPM] = 1'b1;
			next_st.lpm_after_interrupt_return_instr = 1'b0;
		end
		if (ctx.nmi_taken && st.nmi_wide_armed)
		begin
			next_st.fix.force_wide = 1'b1;
			det[phz_pkg::PHZ_H_NMI_WIDE] = 1'b1;
			next_st.nmi_wide_armed = 1'b0;
		end
		if (instr.valid)
		begin
			// window closes on any further instruction, a nop included
			next_st.lpm_after_interrupt_return_instr = st.prev.valid && st.prev.op == phz_pkg::PHZ_OP_LPM_SET
				&& instr.op == phz_pkg::PHZ_OP_INT_RETURN && ctx.int_enable && ctx.in_isr;
			next_st.nmi_wide_armed = st.prev.valid && st.prev.op == phz_pkg::PHZ_OP_LPM_SET
				&& st.prev.src_mode == phz_pkg::PHZ_AM_INDEXED && ctx.nmi_pending
				&& instr.wide && instr.src_mode == phz_pkg::PHZ_AM_REG
				&& instr.dst_mode == phz_pkg::PHZ_AM_REG;
			unique case (instr.op)
				phz_pkg::PHZ_OP_CALL:
				begin
					if (instr.src_mode == phz_pkg::PHZ_AM_REG && instr.src_reg == phz_pkg::PHZ_REG_SP)
					begin
						// first stack word is never executed
						next_st.fix.fetch_valid = 1'b1;
						next_st.fix.fetch_addr = ctx.sp + phz_pkg::PHZ_WORD_STEP;
						det[phz_pkg::PHZ_H_CALL_SP] = 1'b1;
					end
				end
				phz_pkg::PHZ_OP_CALL_ADDR:
				begin
					if (instr.src_mode == phz_pkg::PHZ_AM_REG && instr.src_reg == phz_pkg::PHZ_REG_PC)
					begin
						next_st.fix.save_valid = 1'b1;
						next_st.fix.save_pc = ctx.pc + phz_pkg::PHZ_WORD_STEP
							- phz_pkg::PHZ_SHORT_OFFSET;
						det[phz_pkg::PHZ_H_CALL_ADDR_PC] = 1'b1;
					end
				end
				phz_pkg::PHZ_OP_ADD_ADDR, phz_pkg::PHZ_OP_SUB_ADDR, phz_pkg::PHZ_OP_CMP_ADDR:
				begin
					// only the short immediate form is affected; extended forms stay exact
					if (!instr.extended && instr.src_mode == phz_pkg::PHZ_AM_IMMEDIATE
						&& instr.dst_reg == phz_pkg::PHZ_REG_PC)
					begin
						det[phz_pkg::PHZ_H_ADDR_PC] = 1'b1;
						next_st.fix.pc_valid = instr.op != phz_pkg::PHZ_OP_CMP_ADDR;
						// pc counted past 2 bytes instead of 4
						if (instr.op == phz_pkg::PHZ_OP_SUB_ADDR)
							next_st.fix.pc_value = ctx.pc + phz_pkg::PHZ_WORD_STEP - instr.imm;
						else
							next_st.fix.pc_value = ctx.pc + phz_pkg::PHZ_WORD_STEP + instr.imm;
					end
				end
				phz_pkg::PHZ_OP_MOVA:
				begin
					// move is exact, so no fix is issued
					next_st.fix.pc_valid = 1'b0;
				end
				phz_pkg::PHZ_OP_PUSH_EXT:
				begin
					if (instr.src_mode == phz_pkg::PHZ_AM_AUTOINC && instr.src_reg == phz_pkg::PHZ_REG_SP)
					begin
						next_st.fix.sp_valid = 1'b1;
						next_st.fix.sp_value = ctx.sp_word;
						det[phz_pkg::PHZ_H_PUSH_SP] = 1'b1;
					end
				end
				phz_pkg::PHZ_OP_EXT2:
				begin
					if (st.prev.valid && st.prev.op == phz_pkg::PHZ_OP_EXT2 && st.prev.src_mode == phz_pkg::PHZ_AM_REG
						&& (st.prev.dst_mode == phz_pkg::PHZ_AM_INDEXED
						|| st.prev.dst_mode == phz_pkg::PHZ_AM_ABSOLUTE
						|| st.prev.dst_mode == phz_pkg::PHZ_AM_SYMBOLIC)
						&& instr.dst_reg == phz_pkg::PHZ_REG_PC
						&& (instr.src_mode == phz_pkg::PHZ_AM_INDIRECT
						|| instr.src_mode == phz_pkg::PHZ_AM_AUTOINC
						|| instr.src_mode == phz_pkg::PHZ_AM_INDEXED))
					begin
						next_st.fix.corrupt_next = 1'b1;
						det[phz_pkg::PHZ_H_EXT_WB] = 1'b1;
					end
				end
				phz_pkg::PHZ_OP_OTHER, phz_pkg::PHZ_OP_INT_RETURN, phz_pkg::PHZ_OP_NOP, phz_pkg::PHZ_OP_LPM_SET:
				begin
				end
				default:
				begin
				end
			endcase
			// a nop in between breaks every pairing
			next_st.prev = instr;
		end
		next_st.hit = det;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign fix = st.fix;

	genvar g;
	generate
		for (g = 0; g < phz_pkg::PHZ_NCASE; g++)
		begin : g_strobe
			phz_pulse u_pulse (
				.clk(clk),
				.reset_n(reset_n),
				.detect(st.hit[g]),
				.strobe(hazard[g])
			);
		end
	endgenerate
endmodule
`default_nettype wire

// >>> include/phz_pkg.sv
/*
 phz_pkg: shared types and constants for the pc/sp hazard sequencer.
 assumes one core clock; instructions arrive already decoded into the
 descriptor struct below, one per executed instruction.
*/
`default_nettype none
package phz_pkg;
	// operation classes of an executed instruction
	typedef enum logic [3:0] {
		PHZ_OP_OTHER = 4'h0,
		PHZ_OP_CALL = 4'h1,
		PHZ_OP_CALL_ADDR = 4'h2,
		PHZ_OP_ADD_ADDR = 4'h3,
		PHZ_OP_SUB_ADDR = 4'h4,
		PHZ_OP_CMP_ADDR = 4'h5,
		PHZ_OP_MOVA = 4'h6,
		PHZ_OP_PUSH_EXT = 4'h7,
		PHZ_OP_INT_RETURN = 4'h8,
		PHZ_OP_NOP = 4'h9,
		PHZ_OP_EXT2 = 4'hA,
		PHZ_OP_LPM_SET = 4'hB
	} phz_op_t;

	// source and destination addressing modes
	typedef enum logic [2:0] {
		PHZ_AM_REG = 3'h0,
		PHZ_AM_INDEXED = 3'h1,
		PHZ_AM_ABSOLUTE = 3'h2,
		PHZ_AM_SYMBOLIC = 3'h3,
		PHZ_AM_INDIRECT = 3'h4,
		PHZ_AM_AUTOINC = 3'h5,
		PHZ_AM_IMMEDIATE = 3'h6
	} phz_am_t;

	localparam logic [3:0] PHZ_REG_PC = 4'h0;
	localparam logic [3:0] PHZ_REG_SP = 4'h1;
	localparam int PHZ_AW = 20;
	localparam logic [19:0] PHZ_WORD_STEP = 20'h00002;
	localparam logic [19:0] PHZ_ADDR_STEP = 20'h00004;
	localparam logic [19:0] PHZ_SHORT_OFFSET = 20'h00002;
	localparam int PHZ_NCASE = 7;
	// hazard index into the flag vector
	localparam int PHZ_H_CALL_SP = 0;
	localparam int PHZ_H_NEST_LPM = 1;
	localparam int PHZ_H_EXT_WB = 2;
	localparam int PHZ_H_NMI_WIDE = 3;
	localparam int PHZ_H_ADDR_PC = 4;
	localparam int PHZ_H_PUSH_SP = 5;
	localparam int PHZ_H_CALL_ADDR_PC = 6;

	// one executed instruction
	typedef struct packed {
		logic valid;
		phz_op_t op;
		phz_am_t src_mode;
		phz_am_t dst_mode;
		logic [3:0] src_reg;
		logic [3:0] dst_reg;
		logic extended;
		logic wide;
		logic [19:0] imm;
	} phz_instr_t;

	// architectural context seen alongside the instruction
	typedef struct packed {
		logic [19:0] pc;
		logic [19:0] sp;
		logic [19:0] sp_word;
		logic int_enable;
		logic in_isr;
		logic nmi_pending;
		logic irq_taken;
		logic nmi_taken;
	} phz_ctx_t;

	// anomalous results handed to the core
	typedef struct packed {
		logic fetch_valid;
		logic [19:0] fetch_addr;
		logic save_valid;
		logic [19:0] save_pc;
		logic pc_valid;
		logic [19:0] pc_value;
		logic sp_valid;
		logic [19:0] sp_value;
		logic force_wide;
		logic corrupt_next;
	} phz_fix_t;

	// registered state of the top module
	typedef struct packed {
		phz_instr_t prev;
		logic lpm_after_interrupt_return_instr;
		logic nmi_wide_armed;
		phz_fix_t fix;
		logic [6:0] hit;
	} phz_state_t;
endpackage
`default_nettype wire

// >>> tb/phz_assertions.sv
/* phz_assertions: port timing checks for phz_seq.
 assumes one clock with synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module phz_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// watched ports
	input wire phz_pkg::phz_instr_t instr,
	input wire phz_pkg::phz_ctx_t ctx,
	input wire phz_pkg::phz_fix_t fix,
	input wire logic [6:0] hazard
);
	// unused code on idle cycles so stale fields never match
	logic [3:0] op;
	logic [2:0] sm;
	assign op = instr.valid ? instr.op : 4'hF;
	assign sm = instr.src_mode;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_call_sp;
		op == 4'h1 && sm == 3'h0 && instr.src_reg == 4'h1;
	endsequence
	sequence s_wb;
		op == 4'hA && sm == 3'h0 && instr.dst_mode inside {3'h1, 3'h2, 3'h3};
	endsequence
	sequence s_pc_wr;
		op == 4'hA && instr.dst_reg == 4'h0 && sm inside {3'h1, 3'h4, 3'h5};
	endsequence
	property p_call_sp;
		s_call_sp |=> fix.fetch_valid && fix.fetch_addr == $past(ctx.sp) + 20'h00002;
	endproperty
	a_call_sp: assert property (p_call_sp) else $error("call sp fetch address");
	property p_call_flag;
		s_call_sp |-> ##2 hazard == 7'h01;
	endproperty
	a_call_flag: assert property (p_call_flag) else $error("call sp status");
	property p_nest;
		op == 4'hB ##1 op == 4'h8 && ctx.int_enable && ctx.in_isr ##1 ctx.irq_taken
			|=> fix.save_valid && fix.save_pc == $past(ctx.pc) + 20'h00002;
	endproperty
	a_nest: assert property (p_nest) else $error("nested save pc");
	property p_ext_wb;
		s_wb ##1 s_pc_wr |=> fix.corrupt_next;
	endproperty
	a_ext_wb: assert property (p_ext_wb) else $error("write-back pc corruption");
	property p_nmi;
		op == 4'hB && sm == 3'h1 ##1 instr.valid && instr.wide && sm == 3'h0 && instr.dst_mode == 3'h0
			&& ctx.nmi_pending ##1 ctx.nmi_taken |=> fix.force_wide;
	endproperty
	a_nmi: assert property (p_nmi) else $error("wide handler");
	property p_addr_pc;
		op == 4'h3 && sm == 3'h6 && instr.dst_reg == 4'h0 && !instr.extended
			|=> fix.pc_valid && fix.pc_value == $past(ctx.pc) + 20'h00002 + $past(instr.imm);
	endproperty
	a_addr_pc: assert property (p_addr_pc) else $error("address add pc value");
	property p_mova;
		op == 4'h6 && instr.dst_reg == 4'h0 |=> !fix.pc_valid;
	endproperty
	a_mova: assert property (p_mova) else $error("move wrote pc");
	property p_push;
		op == 4'h7 && sm == 3'h5 && instr.src_reg == 4'h1 |=> fix.sp_valid && fix.sp_value == $past(ctx.sp_word);
	endproperty
	a_push: assert property (p_push) else $error("push sp value");
	property p_call_addr_pc;
		op == 4'h2 && sm == 3'h0 && instr.src_reg == 4'h0 |=> fix.save_valid && fix.save_pc == $past(ctx.pc);
	endproperty
	a_call_addr_pc: assert property (p_call_addr_pc) else $error("call address pc save");
endmodule
bind phz_seq phz_assertions u_phz_assertions (.clk(clk), .reset_n(reset_n), .instr(instr), .ctx(ctx),
	.fix(fix), .hazard(hazard));
`default_nettype wire

// >>> tb/phz_prog.sv
/* phz_prog: program memory model issuing the executed stream.
 assumes the bench calls its tasks, one instruction or idle cycle per call. */
`timescale 1ns/1ps
`default_nettype none
module phz_prog (
	// clock
	input wire logic clk,
	// stream to the sequencer
	output phz_pkg::phz_instr_t instr,
	output phz_pkg::phz_ctx_t ctx
);
	initial
	begin
		instr = '0;
		ctx = '0;
	end
	// context levels stay high so every arming case can occur
	task automatic exec(input int op, sm, dm, sr, dr, e, w);
		@(posedge clk);
		#1;
		instr = {1'b1, 4'(op), 3'(sm), 3'(dm), 4'(sr), 4'(dr), 1'(e), 1'(w), 20'($urandom)};
		ctx = {20'($urandom), 20'($urandom), 20'($urandom), 3'b111, 2'b00};
	endtask
	// idle cycle; stale immediate inverted so it is never reused
	task automatic ev(input logic irq, nmi);
		@(posedge clk);
		#1;
		instr.valid = 1'b0;
		instr.imm = ~instr.imm;
		ctx.irq_taken = irq;
		ctx.nmi_taken = nmi;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/* tb_top: stream bench for phz_seq.
 assumes phz_prog drives the stream and the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; $display("wrong value at %0t: %h", $time, a); end end
module tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	int err_total = 0;
	int check_count = 0;
	logic [6:0] exp_q[$];
	logic [6:0] hazard;
	phz_pkg::phz_instr_t instr;
	phz_pkg::phz_ctx_t ctx;
	always #25 clk = ~clk;
	phz_prog u_phz_prog (.clk(clk), .instr(instr), .ctx(ctx));
	phz_seq u_phz_seq (.clk(clk), .reset_n(reset_n), .instr(instr), .ctx(ctx), .fix(), .hazard(hazard));
	task automatic x(input int op, sm, dm, sr, dr, e, w, h);
		if (h >= 0)
			exp_q.push_back(7'h01 << h);
		u_phz_prog.exec(op, sm, dm, sr, dr, e, w);
	endtask
	task automatic ev(input int i, n, h);
		if (h >= 0)
			exp_q.push_back(7'h01 << h);
		u_phz_prog.ev(i[0], n[0]);
	endtask
	task automatic done(input string s);
		repeat (3) ev(0, 0, -1);
		$display("test %s done", s);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(negedge clk)
	begin
		if (hazard !== 7'h00)
			`CHK(hazard, exp_q.size() ? exp_q.pop_front() : 7'h00)
	end
	initial
	begin
		#(400 * 50);
		err_total++;
		stop_test();
	end
	initial
	begin
		void'($urandom(22));
		repeat (3) @(posedge clk);
		#1 reset_n = 1'b1;
		x(1, 0, 0, 1, 0, 0, 0, 0);
		done("call sp");
		x(11, 0, 0, 0, 0, 0, 0, -1);
		x(8, 0, 0, 0, 0, 0, 0, -1);
		ev(1, 0, 1);
		x(11, 0, 0, 0, 0, 0, 0, -1);
		x(9, 0, 0, 0, 0, 0, 0, -1);
		x(8, 0, 0, 0, 0, 0, 0, -1);
		ev(1, 0, -1);
		done("nested lpm");
		for (int k = 1; k < 4; k++)
		begin
			x(10, 0, k, 0, 2, 1, 0, -1);
			x(10, k == 3 ? 1 : k + 3, 0, 2, 0, 1, 0, 2);
		end
		x(10, 0, 1, 0, 2, 1, 0, -1);
		x(9, 0, 0, 0, 0, 0, 0, -1);
		x(10, 4, 0, 2, 0, 1, 0, -1);
		done("write-back");
		x(11, 1, 0, 2, 0, 0, 0, -1);
		x(10, 0, 0, 2, 2, 1, 1, -1);
		ev(0, 1, 3);
		x(11, 1, 0, 2, 0, 0, 0, -1);
		x(9, 0, 0, 0, 0, 0, 0, -1);
		x(10, 0, 0, 2, 2, 1, 1, -1);
		ev(0, 1, -1);
		done("wide handler");
		for (int k = 3; k < 6; k++)
			x(k, 6, 0, 0, 0, 0, 0, 4);
		x(3, 6, 0, 0, 0, 1, 0, -1);
		x(6, 6, 0, 0, 0, 0, 0, -1);
		x(7, 5, 0, 1, 0, 1, 0, 5);
		x(2, 0, 0, 0, 0, 0, 0, 6);
		done("pc and sp writes");
		`CHK(exp_q.size(), 0)
		stop_test();
	end
endmodule
`default_nettype wire
